// >>> hdl/uart_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module uart_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// =========================================================
	// Handshakes
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_q[rd_q];

	// Storage written only on push, no reset needed for data
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // uart_fifo

// >>> hdl/uart_with_flow_control.sv
// Flow-controlled UART: transmitter, receiver and receive FIFO.
// Operation
// - Reset frame is eight bits, no parity
// - Every frame ends with one stop bit
// - Parity is even or none, never odd
// - Data bits leave least significant first
// - Flow control enabled or disabled by configuration
// - Ready-to-receive off when receiver cannot accept
// - Flow control lines optional, may stay unused
// - Programmable baud divisor, up to 1 Mbps
// - Data moved by DMA streams, no CPU
`timescale 1ns/10ps
module uart_with_flow_control
	import uart_fc_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Configuration
	input  wire logic        cfg_load,
	input  wire logic [15:0] cfg_divisor,
	input  wire logic        cfg_parity_even,
	input  wire logic        cfg_flow_en,
	// Transmit stream from DMA
	input  wire logic        tx_valid,
	output logic             tx_ready,
	input  wire logic [7:0]  tx_data,
	// Receive stream to DMA
	output logic             rx_valid,
	input  wire logic        rx_ready,
	output logic [7:0]       rx_data,
	output logic             rx_parity_err_q,
	output logic             rx_overrun_q,
	// Serial pins
	output logic             txd_q,
	input  wire logic        rxd,
	output logic             ready_to_receive_out,
	input  wire logic        permit_to_send_in
);
	// =========================================================
	// Configuration registers
	logic [15:0] div_q;
	logic        par_q;
	logic        flow_q;
	// Reset frame is eight_bit_no_parity_one_stop
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q  <= RESET_DIVISOR;
			par_q  <= RESET_PARITY;
			flow_q <= RESET_FLOW;
		end else if (cfg_load) begin
			// Divisor clamped so the bit rate never passes the maximum
			div_q  <= (cfg_divisor < MIN_DIVISOR) ? MIN_DIVISOR : cfg_divisor;
			par_q  <= cfg_parity_even;
			flow_q <= cfg_flow_en;
		end
	end

	// =========================================================
	// Transmitter
	ser_state_t  tx_st_q;
	logic [15:0] tx_cnt_q;
	logic [2:0]  tx_bit_q;
	logic [7:0]  tx_sh_q;
	logic        tx_par_q;
	logic        tx_tick;
	logic        tx_permit;

	assign tx_tick   = (tx_cnt_q >= div_q - 16'h0001); // Safe if divisor shrinks mid-bit
	// Permit line ignored when flow control is off, so it may float unused
	assign tx_permit = !flow_q || permit_to_send_in;
	assign tx_ready  = (tx_st_q == ST_IDLE) && tx_permit;

	// Bit timer, restarted on every frame start
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_cnt_q <= '0;
		end else if (tx_st_q == ST_IDLE || tx_tick) begin
			tx_cnt_q <= '0;
		end else begin
			tx_cnt_q <= tx_cnt_q + 16'h0001;
		end
	end

	// Frame sequencer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_q  <= ST_IDLE;
			tx_bit_q <= '0;
			tx_sh_q  <= '0;
			tx_par_q <= 1'b0;
			txd_q    <= 1'b1;
		end else begin
			unique case (tx_st_q)
				ST_IDLE: begin
					txd_q <= 1'b1;
					if (tx_valid && tx_permit) begin
						tx_st_q  <= ST_START;
						tx_sh_q  <= tx_data;
						tx_par_q <= ^tx_data;
						tx_bit_q <= '0;
						txd_q    <= 1'b0;
					end
				end
				ST_START: begin
					if (tx_tick) begin
						tx_st_q <= ST_DATA;
						txd_q   <= tx_sh_q[0];
						tx_sh_q <= {1'b0, tx_sh_q[7:1]};
					end
				end
				ST_DATA: begin
					if (tx_tick) begin
						tx_bit_q <= tx_bit_q + 3'h1;
						if (tx_bit_q == 3'(DATA_BITS-1)) begin
							tx_st_q <= par_q ? ST_PARITY : ST_STOP;
							txd_q   <= par_q ? tx_par_q : 1'b1;
						end else begin
							txd_q   <= tx_sh_q[0];
							tx_sh_q <= {1'b0, tx_sh_q[7:1]};
						end
					end
				end
				ST_PARITY: begin
					if (tx_tick) begin
						tx_st_q <= ST_STOP;
						txd_q   <= 1'b1;
					end
				end
				ST_STOP: begin
					// Single stop bit, then back to idle
					if (tx_tick) begin
						tx_st_q <= ST_IDLE;
					end
				end
				default: tx_st_q <= ST_IDLE;
			endcase
		end
	end

	// =========================================================
	// Receiver
	ser_state_t  rx_st_q;
	logic [15:0] rx_cnt_q;
	logic [2:0]  rx_bit_q;
	logic [7:0]  rx_sh_q;
	logic        rx_par_q;
	logic        rxd_s1_q;
	logic        rxd_s2_q;
	logic        rx_tick;
	logic        rx_push;
	logic        fifo_in_ready;
	// Two-stage resync guards against a line timed by a foreign clock
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
		end else begin
			rxd_s1_q <= rxd;
			rxd_s2_q <= rxd_s1_q;
		end
	end

	// Sample at bit centre: half period after start, full period afterwards
	assign rx_tick = (rx_st_q == ST_START) ? (rx_cnt_q >= {1'b0, div_q[15:1]})
	                                       : (rx_cnt_q >= div_q - 16'h0001);
	// Bit timer; >= keeps a divisor shrunk mid-frame from stranding the count
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt_q <= '0;
		end else if (rx_st_q == ST_IDLE || rx_tick) begin
			rx_cnt_q <= '0;
		end else begin
			rx_cnt_q <= rx_cnt_q + 16'h0001;
		end
	end
	// Frame receiver; a false start (high at centre) is dropped
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_q         <= ST_IDLE;
			rx_bit_q        <= '0;
			rx_sh_q         <= '0;
			rx_par_q        <= 1'b0;
			rx_push         <= 1'b0;
			rx_parity_err_q <= 1'b0;
			rx_overrun_q    <= 1'b0;
		end else begin
			rx_push <= 1'b0;
			unique case (rx_st_q)
				ST_IDLE: begin
					if (!rxd_s2_q) begin
						rx_st_q  <= ST_START;
						rx_bit_q <= '0;
						rx_par_q <= 1'b0;
					end
				end
				ST_START: begin
					if (rx_tick) begin
						rx_st_q <= rxd_s2_q ? ST_IDLE : ST_DATA;
					end
				end
				ST_DATA: begin
					if (rx_tick) begin
						rx_sh_q  <= {rxd_s2_q, rx_sh_q[7:1]};
						rx_par_q <= rx_par_q ^ rxd_s2_q;
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == 3'(DATA_BITS-1)) begin
							rx_st_q <= par_q ? ST_PARITY : ST_STOP;
						end
					end
				end
				ST_PARITY: begin
					if (rx_tick) begin
						rx_st_q         <= ST_STOP;
						rx_parity_err_q <= rx_par_q ^ rxd_s2_q;
					end
				end
				ST_STOP: begin
					// One stop bit only; byte delivered at its centre
					if (rx_tick) begin
						rx_st_q      <= ST_IDLE;
						rx_push      <= 1'b1;
						rx_overrun_q <= !fifo_in_ready;
					end
				end
				default: rx_st_q <= ST_IDLE;
			endcase
		end
	end

	// =========================================================
	// Receive buffer toward DMA
	uart_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (rx_push),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_sh_q),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);
	// Request line goes off (high) once the buffer is full; on when flow is off
	assign ready_to_receive_out = flow_q && !fifo_in_ready;

	// =========================================================
	// Checks
	sequence s_start_bit;
		tx_st_q == ST_IDLE && tx_valid && tx_permit;
	endsequence

	property p_idle_high;
		@(posedge core_clk) disable iff (!rst_n)
		(tx_st_q == ST_IDLE) |-> txd_q;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line not idle high");
	property p_start_low;
		@(posedge core_clk) disable iff (!rst_n)
		s_start_bit |=> (!txd_q && tx_st_q == ST_START);
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");
	property p_no_start_blocked;
		@(posedge core_clk) disable iff (!rst_n)
		(tx_st_q == ST_IDLE && flow_q && !permit_to_send_in) |=> tx_st_q == ST_IDLE;
	endproperty
	a_no_start_blocked: assert property (p_no_start_blocked)
		else $error("frame started without permit");
	property p_stop_high;
		@(posedge core_clk) disable iff (!rst_n)
		(tx_st_q == ST_STOP) |-> txd_q;
	endproperty
	a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
	property p_rtr_off_full;
		@(posedge core_clk) disable iff (!rst_n)
		(flow_q && !fifo_in_ready) |-> ready_to_receive_out;
	endproperty
	a_rtr_off_full: assert property (p_rtr_off_full) else $error("ready line on when full");
	property p_div_min;
		@(posedge core_clk) disable iff (!rst_n)
		div_q >= MIN_DIVISOR;
	endproperty
	a_div_min: assert property (p_div_min) else $error("baud above maximum");
	property p_lsb_first;
		@(posedge core_clk) disable iff (!rst_n)
		(tx_st_q == ST_START && tx_tick) |=> txd_q == $past(tx_sh_q[0]);
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("first data bit not lsb");
	// Leaving the data bits with parity off must never enter the parity bit
	property p_no_parity_skip;
		@(posedge core_clk) disable iff (!rst_n)
		(tx_st_q == ST_DATA && !par_q) |=> tx_st_q != ST_PARITY;
	endproperty
	a_no_parity_skip: assert property (p_no_parity_skip) else $error("parity sent when off");
endmodule // uart_with_flow_control

// >>> pkg/uart_fc_pkg.sv
// Package: constants and types for the flow-controlled UART.
package uart_fc_pkg;
	// =========================================================
	// Frame format and timing
	localparam int          DATA_BITS      = 8;           // Eight data bits
	localparam int          STOP_BITS      = 1;           // Exactly one stop bit
	localparam int          CLK_HZ         = 200_000_000;
	localparam int          MAX_BAUD_BPS   = 1_000_000;   // Fastest supported rate
	// Smallest divisor allowed: one bit may be no shorter than this many clocks
	localparam logic [15:0] MIN_DIVISOR    = 16'(CLK_HZ / MAX_BAUD_BPS);
	localparam logic [15:0] RESET_DIVISOR  = 16'h06C8;    // 115200 bps after reset
	localparam logic        RESET_PARITY   = 1'b0;        // No parity after reset
	localparam logic        RESET_FLOW     = 1'b0;        // No flow control after reset
	localparam int          FIFO_DEPTH     = 8;
	localparam int          FIFO_WIDTH     = 8;

	// =========================================================
	// Serial engine states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_START  = 3'b001,
		ST_DATA   = 3'b010,
		ST_PARITY = 3'b011,
		ST_STOP   = 3'b100
	} ser_state_t;
endpackage

// >>> verif/test_uart_with_flow_control.sv
// Self-checking testbench for the flow-controlled UART.
`timescale 1ns/10ps
module test_uart_with_flow_control;
	import uart_fc_pkg::*;
	logic core_clk = 1'b0, rst_n = 1'b0, cfg_load = 1'b0, cfg_parity_even = 1'b0;
	logic cfg_flow_en = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0, rxd, permit_to_send_in;
	logic [15:0] cfg_divisor = 16'h00C8;
	logic [7:0] tx_data = 8'h00, rx_data, d;
	logic tx_ready, rx_valid, rx_parity_err_q, rx_overrun_q, txd_q, ready_to_receive_out;
	logic p, st, sp;
	int fails = 0, comparisons = 0;

	// =========================================================
	// 200 MHz clock
	always #2.5 core_clk = ~core_clk;

	uart_with_flow_control uart_with_flow_control_i (.core_clk(core_clk), .rst_n(rst_n),
		.cfg_load(cfg_load), .cfg_divisor(cfg_divisor), .cfg_parity_even(cfg_parity_even),
		.cfg_flow_en(cfg_flow_en), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.rx_parity_err_q(rx_parity_err_q), .rx_overrun_q(rx_overrun_q), .txd_q(txd_q),
		.rxd(rxd), .ready_to_receive_out(ready_to_receive_out),
		.permit_to_send_in(permit_to_send_in));
	uart_peer uart_peer_i (.core_clk(core_clk), .txd_q(txd_q), .rxd(rxd),
		.ready_to_receive_out(ready_to_receive_out), .permit_to_send_in(permit_to_send_in));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Pulse a configuration load, applied off the sampling edge
	task automatic cfg(input logic [15:0] dv, input logic par, input logic fl);
		@(posedge core_clk);
		#1 {cfg_divisor, cfg_parity_even, cfg_flow_en, cfg_load} = {dv, par, fl, 1'b1};
		@(posedge core_clk);
		#1 cfg_load = 1'b0;
	endtask

	// Offer a byte and hold it until the edge that sees tx_ready high
	task automatic tx_byte(input logic [7:0] v);
		@(posedge core_clk);
		#1 {tx_valid, tx_data} = {1'b1, v};
		for (int n = 0; n < 40000; n++) begin
			@(negedge core_clk);
			if (tx_ready === 1'b1)
				break;
		end
		@(posedge core_clk);
		#1 tx_valid = 1'b0;
	endtask

	// Frame leaves in the given format and carries the given byte
	task automatic tx_frame(input int dv, input bit par, input logic [7:0] v);
		fork
			tx_byte(v);
			uart_peer_i.get_frame(dv, par, d, p, st, sp);
		join
		chk("start", 16'h0, st);
		chk("data", v, d);
		chk("parity", par ? ^v : 1'b0, p);
		chk("stop", 16'h1, sp);
	endtask

	// Wait for a received byte, compare it, then pop it
	task automatic rx_pop(input logic [7:0] v);
		for (int n = 0; n < 2000 && rx_valid !== 1'b1; n++)
			@(negedge core_clk);
		chk("rx_data", v, rx_data);
		@(posedge core_clk);
		#1 rx_ready = 1'b1;
		@(posedge core_clk);
		#1 rx_ready = 1'b0;
	endtask

	// =========================================================
	// Scenarios
	task automatic t_reset_frame;
		chk("txd idle", 16'h1, txd_q);
		chk("rts idle", 16'h0, ready_to_receive_out);
		tx_frame(1736, 0, 8'h96);
	endtask

	task automatic t_parity_tx;
		cfg(16'h0010, 1'b1, 1'b0);
		tx_frame(200, 1, 8'h07);
		tx_frame(200, 1, 8'h81);
	endtask

	// Blocked while permit is withheld with flow on; permit ignored with flow off
	task automatic t_flow_tx;
		cfg(16'h00C8, 1'b0, 1'b1);
		uart_peer_i.set_permit(1'b0);
		@(posedge core_clk);
		#1 {tx_valid, tx_data} = {1'b1, 8'h5A};
		repeat (300) @(negedge core_clk);
		chk("tx_ready held", 16'h0, tx_ready);
		chk("txd held", 16'h1, txd_q);
		@(posedge core_clk);
		#1 tx_valid = 1'b0;
		uart_peer_i.set_permit(1'b1);
		tx_frame(200, 0, 8'h5A);
		cfg(16'h00C8, 1'b0, 1'b0);
		uart_peer_i.set_permit(1'b0);
		tx_frame(200, 0, 8'hC3);
		uart_peer_i.set_permit(1'b1);
	endtask

	task automatic t_rx_parity;
		cfg(16'h00C8, 1'b1, 1'b0);
		uart_peer_i.send_frame(200, 1, 0, 8'hA5);
		rx_pop(8'hA5);
		chk("perr clear", 16'h0, rx_parity_err_q);
		uart_peer_i.send_frame(200, 1, 1, 8'h3C);
		repeat (10) @(negedge core_clk);
		chk("perr set", 16'h1, rx_parity_err_q);
		rx_pop(8'h3C);
	endtask

	task automatic t_fill;
		cfg(16'h00C8, 1'b0, 1'b1);
		for (int i = 0; i < 8; i++)
			uart_peer_i.send_frame(200, 0, 0, 8'h10 + 8'(i));
		repeat (10) @(negedge core_clk);
		chk("rts off", 16'h1, ready_to_receive_out);
		uart_peer_i.send_frame(200, 0, 0, 8'hEE);
		repeat (10) @(negedge core_clk);
		chk("overrun", 16'h1, rx_overrun_q);
		for (int i = 0; i < 8; i++)
			rx_pop(8'h10 + 8'(i));
		repeat (3) @(negedge core_clk);
		chk("dropped byte", 16'h0, rx_valid);
		chk("rts on", 16'h0, ready_to_receive_out);
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		#1 rst_n = 1'b1;
		t_reset_frame();
		t_parity_tx();
		t_flow_tx();
		t_rx_parity();
		t_fill();
		tally_and_finish();
	end

	// Watchdog: about 48k cycles expected, limit at 80k cycles
	initial begin
		#400000;
		fails++;
		tally_and_finish();
	end
endmodule // test_uart_with_flow_control

// >>> verif/uart_peer.sv
// Far-side serial peer: sends frames, captures frames and drives the permit line.
`timescale 1ns/10ps
module uart_peer (
	// Clock
	input  wire logic core_clk,
	// Serial lines
	input  wire logic txd_q,
	output logic      rxd,
	input  wire logic ready_to_receive_out,
	output logic      permit_to_send_in
);
	// =========================================================
	// Line rests high between frames; sending permitted at start
	initial begin
		rxd = 1'b1;
		permit_to_send_in = 1'b1;
	end

	// Hold the current bit for one bit period
	task automatic bit_time(input int div);
		repeat (div) @(posedge core_clk);
		#1;
	endtask

	// Low start, data LSB first, even parity if asked, one high stop
	task automatic send_frame(input int div, input bit par, input bit bad, input logic [7:0] d);
		rxd = 1'b0;
		bit_time(div);
		for (int i = 0; i < 8; i++) begin
			rxd = d[i];
			bit_time(div);
		end
		if (par) begin
			rxd = ^d ^ bad;
			bit_time(div);
		end
		rxd = 1'b1;
		bit_time(div);
	endtask

	// Peer grants or withdraws its permission for the device to send
	task automatic set_permit(input bit v);
		permit_to_send_in = v;
	endtask

	// Wait for a start bit, then sample every bit at its centre, on the
	// falling edge so the registered line has settled
	task automatic get_frame(input int div, input bit par, output logic [7:0] d,
			output logic p, output logic st, output logic sp);
		for (int n = 0; n < 40000 && txd_q !== 1'b0; n++)
			@(negedge core_clk);
		repeat (div / 2) @(negedge core_clk);
		st = txd_q;
		for (int i = 0; i < 8; i++) begin
			repeat (div) @(negedge core_clk);
			d[i] = txd_q;
		end
		p = 1'b0;
		if (par) begin
			repeat (div) @(negedge core_clk);
			p = txd_q;
		end
		repeat (div) @(negedge core_clk);
		sp = txd_q;
	endtask
endmodule // uart_peer
